// ### core/spc_profiler.sv
// Speed command profiler: terminal start/stop/reverse, soft-start ramp,
// S-curve smoothing, zero clamp lock, speed-reached and rotating flags.
// Assumes speed_cmd and motor_speed come from logic on mclk; the four
// terminal inputs are asynchronous pins.
`timescale 1ns/100ps

// Contract
// - Terminal control: analog magnitude, terminals run/stop
// - Stop, none or both runs: decelerate to zero
// - Forward run ramps to command at accel rate
// - Reverse: zero first, then negative, decel time
// - Step changes become constant-slope ramps
// - accel_time is zero-to-rated time
// - decel_time is rated-to-zero time
// - S-curve rounds ramp ends over scurve_time
// - Zero clamp active only when enabled
// - Lock when command magnitude below clamp level
// - Locked: ignore command, reference to zero fast
// - Reached while speed error below window
// - Reached uses error magnitude, both directions
// - Rotating while speed magnitude above threshold
module spc_profiler
  import spc_pkg::*;
#(
  parameter int ramp_unit_cyc = SPC_RAMP_UNIT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Speed inputs
  input wire logic signed [15:0] speed_cmd,
  input wire logic signed [15:0] motor_speed,
  input wire logic [14:0] rated_speed,
  // Terminal pins
  input wire logic run_fwd_in,
  input wire logic run_rev_in,
  input wire logic stop_in,
  input wire logic zero_lock_input,
  // Settings
  input wire logic analog_terminal_ctrl_en,
  input wire logic [14:0] accel_time,
  input wire logic [14:0] decel_time,
  input wire logic scurve_en,
  input wire logic [14:0] scurve_time,
  input wire logic zero_clamp_en,
  input wire logic [14:0] zero_clamp_level,
  input wire logic [14:0] speed_window,
  input wire logic [14:0] rotate_threshold,
  // Outputs
  output logic signed [15:0] speed_ref_out,
  output logic speed_reached_out,
  output logic rotating_out,
  output logic zero_locked_out
);

  // ==========================================================
  // Pin synchronisers
  // Order: {zero_lock, stop, rev, fwd}
  logic [3:0] pin_s1_reg;     // First stage, read only by second
  logic [3:0] pin_s2_reg;
  logic [3:0] pin_s3_reg;
  logic [3:0] pin_reg;        // Accepted levels
  logic [3:0] pin_next;

  // Accept a new level only once stages two and three agree.
  // A pulse shorter than two clocks is dropped as a glitch, and the
  // few clocks of latency are far below any ramp time.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_next[i] = (pin_s2_reg[i] == pin_s3_reg[i]) ? pin_s3_reg[i] : pin_reg[i];
    end
  end

  // Synchroniser flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      pin_s3_reg <= 4'h0;
      pin_reg <= 4'h0;
    end else begin
      pin_s1_reg <= {zero_lock_input, stop_in, run_rev_in, run_fwd_in};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_reg <= pin_next;
    end
  end

  logic fwd_on;    // Forward run terminal
  logic rev_on;    // Reverse run terminal
  logic stop_on;   // Start/stop button
  logic clamp_on;  // Zero clamp terminal
  assign fwd_on = pin_reg[0];
  assign rev_on = pin_reg[1];
  assign stop_on = pin_reg[2];
  assign clamp_on = pin_reg[3];

  // ==========================================================
  // Mode sequencer
  spc_mode_e mode_reg;
  spc_mode_e mode_next;
  logic signed [15:0] lin_reg;    // Linear ramp reference
  logic [16:0] cmd_mag;           // |speed_cmd|
  logic lock_req;                 // Clamp condition this cycle
  logic term_stop;                // Terminal stop request
  logic lock_now;                 // Lock holds after this edge

  always_comb begin
    cmd_mag = spc_abs(17'(speed_cmd));
    // Enable gates the clamp terminal entirely
    lock_req = zero_clamp_en & clamp_on & (cmd_mag < {2'b00, zero_clamp_level});
    // Button, neither run or both runs all mean stop
    term_stop = stop_on | (fwd_on == rev_on);
  end

  // Next mode; settings are read live so changes act at once
  // Lock is tested first so the clamp wins over any run request
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      SPC_MODE_LOCK: begin
        // Leave lock when terminal drops or command rises again
        if (!(zero_clamp_en & clamp_on) || cmd_mag >= {2'b00, zero_clamp_level}) begin
          mode_next = SPC_MODE_STOP;
        end
      end
      default: begin
        if (lock_req) begin
          mode_next = SPC_MODE_LOCK;
        end else if (!analog_terminal_ctrl_en) begin
          // Plain analog mode: reference follows command directly
          mode_next = SPC_MODE_FWD;
        end else if (term_stop) begin
          mode_next = SPC_MODE_STOP;
        end else if (fwd_on) begin
          mode_next = SPC_MODE_FWD;
        end else if (mode_reg != SPC_MODE_REV) begin
          // Brake through standstill only while still turning forward
          mode_next = (lin_reg > 16'sh0000) ? SPC_MODE_REV_STOP : SPC_MODE_REV;
        end
      end
    endcase
  end

  // Entering lock zeroes the reference on the edge that raises the flag
  assign lock_now = (mode_next == SPC_MODE_LOCK);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_reg <= SPC_MODE_STOP;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ==========================================================
  // Ramp target and rate selection
  logic signed [15:0] target;     // Where the ramp is heading
  logic toward_zero;              // Moving magnitude down
  logic use_decel;                // Decel time selected
  logic [14:0] ramp_time;

  always_comb begin
    target = 16'sh0000;
    case (mode_reg)
      SPC_MODE_FWD: begin
        // Terminal control takes only the magnitude of the command
        if (analog_terminal_ctrl_en) begin
          // Full negative scale has no positive twin, so clip it
          target = cmd_mag[15] ? 16'sh7fff : 16'(cmd_mag);
        end else begin
          target = speed_cmd;
        end
      end
      SPC_MODE_REV: target = 16'(-$signed(cmd_mag));
      SPC_MODE_STOP: target = 16'sh0000;
      SPC_MODE_REV_STOP: target = 16'sh0000;
      SPC_MODE_LOCK: target = 16'sh0000;
      default: target = 16'sh0000;
    endcase
    toward_zero = (lin_reg > 16'sh0000 && target < lin_reg) ||
                  (lin_reg < 16'sh0000 && target > lin_reg);
    // Decel is chosen whenever the magnitude falls, also across zero
    // Reverse sequence runs entirely on the decel time
    use_decel = toward_zero || mode_reg == SPC_MODE_REV_STOP || mode_reg == SPC_MODE_REV;
    // Time per rated speed; duration scales with speed change
    ramp_time = use_decel ? decel_time : accel_time;
  end

  // ==========================================================
  // Linear ramp: one 0.1 r/min step per stepper pulse
  logic lin_step;
  logic lin_at;   // Ramp sits on target
  logic signed [15:0] lin_next;

  // Clearing the stepper on target makes the next ramp start from rest
  assign lin_at = (lin_reg == target);

  // Rated speed over ramp_time ms gives the constant slope
  spc_stepper #(
    .unit_cyc(ramp_unit_cyc)
  ) u_lin_step (
    .mclk(mclk),
    .rst(rst),
    .clr(lin_at),
    .numer({1'b0, rated_speed}),
    .time_ms(ramp_time),
    .step(lin_step)
  );

  always_comb begin
    lin_next = lin_reg;
    if (lock_now) begin
      // Lock skips the ramp so the motor stops at once
      lin_next = 16'sh0000;
    end else if (lin_step && !lin_at) begin
      // Never jump: move one unit toward the target
      lin_next = (target > lin_reg) ? lin_reg + 16'sh0001 : lin_reg - 16'sh0001;
    end
  end

  // ==========================================================
  // S-curve stage: first-order follower with time constant scurve_time.
  // Trade-off: a lag instead of a jerk-limited profile keeps it small.
  // Limitation: the last few units settle one step per time constant.
  logic signed [15:0] sc_reg;
  logic signed [15:0] sc_next;
  logic [16:0] sc_err;
  logic sc_step;
  logic sc_active;

  always_comb begin
    sc_err = spc_abs(17'(lin_reg) - 17'(sc_reg));
    sc_active = scurve_en && scurve_time != 15'h0000 && !lock_now;
  end

  // Rate proportional to remaining error rounds both ramp ends
  spc_stepper #(
    .unit_cyc(ramp_unit_cyc)
  ) u_sc_step (
    .mclk(mclk),
    .rst(rst),
    .clr(!sc_active || sc_err == 17'h00000),
    .numer(sc_err[16] ? 16'hffff : sc_err[15:0]),
    .time_ms(scurve_time),
    .step(sc_step)
  );

  always_comb begin
    if (!sc_active) begin
      // Disabled or locked: pass the linear ramp straight on
      sc_next = lin_next;
    end else if (sc_step && sc_reg != lin_reg) begin
      sc_next = (lin_reg > sc_reg) ? sc_reg + 16'sh0001 : sc_reg - 16'sh0001;
    end else begin
      sc_next = sc_reg;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lin_reg <= 16'sh0000;
      sc_reg <= 16'sh0000;
    end else begin
      lin_reg <= lin_next;
      sc_reg <= sc_next;
    end
  end

  // ==========================================================
  // Status flags, refreshed every clock from current values
  logic reached_next;
  logic rotating_next;
  logic [16:0] err_mag;
  logic [16:0] mot_mag;

  always_comb begin
    // Both compares are strict: a value equal to the setting fails
    // Magnitude only, so direction does not matter
    err_mag = spc_abs(17'(motor_speed) - 17'(sc_reg));
    mot_mag = spc_abs(17'(motor_speed));
    reached_next = err_mag < {2'b00, speed_window};
    rotating_next = mot_mag > {2'b00, rotate_threshold};
  end

  // Output registers
  // so downstream logic never sees combinational glitches
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      speed_ref_out <= 16'sh0000;
      speed_reached_out <= 1'b0;
      rotating_out <= 1'b0;
      zero_locked_out <= 1'b0;
    end else begin
      speed_ref_out <= sc_next;
      speed_reached_out <= reached_next;
      rotating_out <= rotating_next;
      zero_locked_out <= lock_now;
    end
  end

endmodule // spc_profiler

// ### core/spc_pkg.sv
// Shared constants for the speed command profiler.
// Assumes one 40 MHz control clock; all settings arrive as plain ports.
package spc_pkg;

  // ==========================================================
  // Clock and time base
  localparam int SPC_CLK_PERIOD_NS = 25;      // mclk period
  localparam int SPC_RAMP_UNIT_MS = 1;        // Unit of all ramp times
  localparam int SPC_RAMP_UNIT_CYC = SPC_RAMP_UNIT_MS * 1000000 / SPC_CLK_PERIOD_NS;

  // ==========================================================
  // Widths
  localparam int SPC_SPD_W = 16;              // Signed speed, 0.1 r/min units
  localparam int SPC_TIME_W = 15;             // Ramp and S-curve times in ms
  localparam int SPC_LVL_W = 15;              // Unsigned speed levels

  // ==========================================================
  // Setting defaults after power-up (applied by the settings owner)
  localparam logic SPC_TERM_CTRL_DEF = 1'b0;
  localparam logic [14:0] SPC_ACCEL_DEF = 15'h00c8;      // 200 ms
  localparam logic [14:0] SPC_DECEL_DEF = 15'h00c8;      // 200 ms
  localparam logic [14:0] SPC_SCURVE_T_DEF = 15'h0064;   // 100 ms
  localparam logic SPC_SCURVE_EN_DEF = 1'b0;
  localparam logic SPC_CLAMP_EN_DEF = 1'b0;
  localparam logic [14:0] SPC_CLAMP_LVL_DEF = 15'h0032;  // 5.0 r/min
  localparam logic [14:0] SPC_WINDOW_DEF = 15'h012c;     // 30.0 r/min
  localparam logic [14:0] SPC_ROTATE_DEF = 15'h012c;     // 30.0 r/min

  // ==========================================================
  // Run modes of the terminal sequencer
  typedef enum logic [2:0] {
    SPC_MODE_STOP = 3'b000,      // Reference heading to zero
    SPC_MODE_FWD = 3'b001,       // Forward run to command
    SPC_MODE_REV_STOP = 3'b010,  // Reverse asked, braking to zero first
    SPC_MODE_REV = 3'b011,       // Reverse run to command
    SPC_MODE_LOCK = 3'b100       // Zero clamp lock
  } spc_mode_e;

  // Magnitude of a 17-bit signed value
  function automatic logic [16:0] spc_abs(input logic signed [16:0] v);
    spc_abs = v[16] ? 17'(-v) : 17'(v);
  endfunction

endpackage

// ### core/spc_stepper.sv
// Rate accumulator: emits one step pulse each time the running sum of
// numer reaches time_ms ramp units. Used for the linear ramp and S-curve.
`timescale 1ns/100ps

module spc_stepper #(
  parameter int unit_cyc = 40000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Rate control
  input wire logic clr,
  input wire logic [15:0] numer,
  input wire logic [14:0] time_ms,
  // Step out
  output logic step
);

  logic [31:0] acc_reg;   // Fractional progress toward next step
  logic [31:0] acc_next;
  logic step_next;
  logic [31:0] thr;       // Steps fire at this sum
  logic [31:0] acc_sum;

  // ==========================================================
  // Next-state: at most one step per clock keeps the output monotonic
  always_comb begin
    thr = 32'({17'h00000, time_ms} * 32'(unit_cyc));
    acc_sum = acc_reg + {16'h0000, numer};
    acc_next = acc_sum;
    step_next = 1'b0;
    if (clr) begin
      // Target reached; drop leftover fraction
      acc_next = 32'h0000_0000;
    end else if (acc_sum >= thr) begin
      step_next = 1'b1;
      // Keep the excess over thr, but clear it to zero if it still reaches thr, so a too-steep rate cannot wind it up
      acc_next = ((acc_sum - thr) >= thr) ? 32'h0000_0000 : acc_sum - thr;
    end
  end

  // Register stage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_reg <= 32'h0000_0000;
      step <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      step <= step_next;
    end
  end

endmodule // spc_stepper

// ### tb/spc_profiler_properties.sv
// Checker for the speed command profiler, watching its top ports.
// Assumes it is bound onto spc_profiler: one mclk domain, async high rst.
`timescale 1ns/100ps

module spc_profiler_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Speed and pin inputs
  input wire logic signed [15:0] speed_cmd,
  input wire logic signed [15:0] motor_speed,
  input wire logic run_fwd_in,
  input wire logic run_rev_in,
  input wire logic stop_in,
  // Settings
  input wire logic analog_terminal_ctrl_en,
  input wire logic scurve_en,
  input wire logic zero_clamp_en,
  input wire logic [14:0] zero_clamp_level,
  input wire logic [14:0] speed_window,
  input wire logic [14:0] rotate_threshold,
  // Outputs
  input wire logic signed [15:0] speed_ref_out,
  input wire logic speed_reached_out,
  input wire logic rotating_out,
  input wire logic zero_locked_out
);
  // ==========================================================
  // Helpers
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Widened magnitude, so a full-scale negative value cannot wrap
  function automatic logic [16:0] mag(input logic signed [16:0] v);
    mag = v[16] ? 17'(-v) : 17'(v);
  endfunction
  // Reference, speed and window all unchanged since the last edge
  sequence quiet_s;
    $stable(speed_ref_out) && $stable(motor_speed) && $stable(speed_window);
  endsequence
  // Terminal stop held long enough to pass the pin synchronisers
  sequence stop_s;
    (analog_terminal_ctrl_en && stop_in) [*6];
  endsequence
  // Reverse alone held long enough to pass the synchronisers
  sequence rev_s;
    (analog_terminal_ctrl_en && run_rev_in && !run_fwd_in && !stop_in) [*6];
  endsequence

  // ==========================================================
  // Assertions
  rot_flag_a: assert property (!$past(rst) |-> rotating_out ==
    (mag($past(motor_speed)) > $past(rotate_threshold))) else $error("rotating flag wrong");
  reach_flag_a: assert property (quiet_s [*3] |-> speed_reached_out ==
    (mag(motor_speed - speed_ref_out) < speed_window)) else $error("reached flag wrong");
  ramp_slope_a: assert property (!zero_locked_out && !scurve_en && !$past(scurve_en)
    |-> mag(speed_ref_out - $past(speed_ref_out)) <= 17'h00001) else $error("ramp step too big");
  lock_zero_a: assert property (zero_locked_out |-> speed_ref_out == 16'sh0000)
    else $error("locked reference not zero");
  lock_gate_a: assert property (!zero_clamp_en |=> !zero_locked_out)
    else $error("lock while clamp disabled");
  lock_level_a: assert property ($rose(zero_locked_out) |->
    mag($past(speed_cmd)) < $past(zero_clamp_level)) else $error("lock above clamp level");
  stop_decay_a: assert property (stop_s |=>
    mag(speed_ref_out) <= mag($past(speed_ref_out))) else $error("reference grew in stop");
  rev_fall_a: assert property (rev_s |=> speed_ref_out <= $past(speed_ref_out))
    else $error("reference rose in reverse");
endmodule // spc_profiler_props

// ### tb/spc_motor_model.sv
// Servo speed loop stand-in: measured speed trails the reference.
// Assumes the bench may pin the measured speed to probe the flags.
`timescale 1ns/100ps

module spc_motor_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Reference and test override
  input wire logic signed [15:0] speed_ref,
  input wire logic pin_en,
  input wire logic signed [15:0] pin_val,
  // Measured speed
  output logic signed [15:0] motor_speed
);
  logic signed [15:0] spd_reg; // Lagged speed
  logic signed [15:0] spd_next; // Next lagged speed
  // Quarter-step lag; from below it settles up to 3 short, like a real loop
  always_comb begin
    spd_next = spd_reg + ((speed_ref - spd_reg) >>> 2);
  end
  // Register the lag state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      spd_reg <= 16'sh0000;
    end else begin
      spd_reg <= spd_next;
    end
  end
  assign motor_speed = pin_en ? pin_val : spd_reg;
endmodule // spc_motor_model

// ### tb/spc_profiler_tb_top.sv
// Self-checking bench for spc_profiler driving a lagging motor model.
// Assumes ramp_unit_cyc of 4, so one ms of ramp time is four clocks.
`timescale 1ns/100ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0d seen %0d", nm, e, a); end end

module spc_profiler_tb_top;
  import spc_pkg::*;
  localparam int UC = 4; // Clocks per ms
  localparam int ACC_N = 50 * UC * 60 / 100; // Accel 50 ms, rated 100
  localparam int DEC_N = 25 * UC * 60 / 100; // Decel 25 ms
  logic mclk, rst, fwd, rev, stp, zl, ten, sen, zen, pin, rch, rot, lck;
  logic signed [15:0] cmd, ref_o, msp, pv;
  logic [14:0] thr, win;
  int error_cnt, num_checks, n;

  spc_profiler #(.ramp_unit_cyc(UC)) dut (.mclk(mclk), .rst(rst),
    .speed_cmd(cmd), .motor_speed(msp), .rated_speed(15'h0064), .run_fwd_in(fwd),
    .run_rev_in(rev), .stop_in(stp), .zero_lock_input(zl), .analog_terminal_ctrl_en(ten),
    .accel_time(15'h0032), .decel_time(15'h0019), .scurve_en(sen), .scurve_time(15'h0005),
    .zero_clamp_en(zen), .zero_clamp_level(15'h001e), .speed_window(win),
    .rotate_threshold(thr), .speed_ref_out(ref_o), .speed_reached_out(rch),
    .rotating_out(rot), .zero_locked_out(lck));
  spc_motor_model u_motor (.mclk(mclk), .rst(rst), .speed_ref(ref_o), .pin_en(pin),
    .pin_val(pv), .motor_speed(msp));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Print counts and verdict, then stop
  task automatic conclude();
    $display("Counts: %0d checks, %0d mismatches", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Bounded wait for the reference to come within tol of v; n counts clocks
  task automatic wait_ref(input logic signed [15:0] v, input int tol);
    n = 0;
    while (!((ref_o >= v - tol) === 1'b1 && (ref_o <= v + tol) === 1'b1) && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    `CHK("reference wait", v, ref_o)
    if (n >= 3000) conclude();
  endtask

  initial begin
    error_cnt = 0;
    num_checks = 0;
    rst = 1'b1;
    {fwd, rev, stp, zl, ten, sen, zen, pin} = 8'h00;
    cmd = 16'sh0000;
    pv = 16'sh0000;
    thr = 15'h001e;
    win = 15'h0005;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    // Direct command: ramp up, reverse, back to zero
    @(posedge mclk) cmd <= 16'sh003c;
    wait_ref(16'sh003c, 0);
    `CHK("accel time", 1'b1, n inside {[ACC_N - 4 : ACC_N + 6]})
    repeat (40) @(negedge mclk);
    `CHK("reached fwd", 1'b1, rch)
    `CHK("rotating fwd", 1'b1, rot)
    @(posedge mclk) cmd <= -16'sh003c;
    wait_ref(-16'sh003c, 0);
    repeat (40) @(negedge mclk);
    `CHK("reached rev", 1'b1, rch)
    `CHK("rotating rev", 1'b1, rot)
    @(posedge mclk) cmd <= 16'sh0000;
    wait_ref(16'sh0000, 0);
    `CHK("decel time", 1'b1, n inside {[DEC_N - 4 : DEC_N + 6]})
    $display("Test ramp done");
    // Pinned motor speed at the flag boundaries
    @(posedge mclk) pin <= 1'b1;
    pv <= 16'sh001e;
    repeat (3) @(negedge mclk);
    `CHK("rot at thr", 1'b0, rot)
    @(posedge mclk) thr <= 15'h001d;
    repeat (2) @(negedge mclk);
    `CHK("rot new thr", 1'b1, rot)
    @(posedge mclk) pv <= -16'sh0005;
    repeat (3) @(negedge mclk);
    `CHK("reach at win", 1'b0, rch)
    @(posedge mclk) pv <= -16'sh0004;
    repeat (3) @(negedge mclk);
    `CHK("reach in win", 1'b1, rch)
    @(posedge mclk) win <= 15'h0004;
    repeat (2) @(negedge mclk);
    `CHK("reach new win", 1'b0, rch)
    @(posedge mclk) pin <= 1'b0;
    $display("Test flags done");
    // Terminal control: idle, forward, both, reverse, stop
    @(posedge mclk) ten <= 1'b1;
    cmd <= 16'sh0028;
    repeat (20) @(negedge mclk);
    `CHK("no run held", 16'sh0000, ref_o)
    @(posedge mclk) fwd <= 1'b1;
    wait_ref(16'sh0028, 0);
    @(posedge mclk) rev <= 1'b1;
    wait_ref(16'sh0000, 0);
    @(posedge mclk) fwd <= 1'b0;
    wait_ref(-16'sh0028, 0);
    @(posedge mclk) stp <= 1'b1;
    wait_ref(16'sh0000, 0);
    repeat (10) @(negedge mclk);
    `CHK("stop holds", 16'sh0000, ref_o)
    @(posedge mclk) {stp, rev, ten} <= 3'h0;
    $display("Test terminal done");
    // Zero clamp: ignored while disabled, then lock and release
    @(posedge mclk) cmd <= 16'sh0014;
    zl <= 1'b1;
    wait_ref(16'sh0014, 0);
    repeat (10) @(negedge mclk);
    `CHK("clamp off", 1'b0, lck)
    @(posedge mclk) zen <= 1'b1;
    repeat (6) @(negedge mclk);
    `CHK("clamp lock", 1'b1, lck)
    `CHK("lock ref", 16'sh0000, ref_o)
    @(posedge mclk) cmd <= 16'sh0064;
    wait_ref(16'sh0064, 0);
    `CHK("lock left", 1'b0, lck)
    $display("Test clamp done");
    // S-curve rounding stretches the stop beyond the linear time
    @(posedge mclk) {zen, zl, sen} <= 3'h1;
    @(posedge mclk) cmd <= 16'sh0000;
    wait_ref(16'sh0000, 0);
    `CHK("scurve slower", 1'b1, n > 25 * UC * 100 / 100)
    $display("Test scurve done");
    conclude();
  end
endmodule // spc_profiler_tb_top

bind spc_profiler spc_profiler_props u_props (.mclk(mclk), .rst(rst), .speed_cmd(speed_cmd),
  .motor_speed(motor_speed), .run_fwd_in(run_fwd_in), .run_rev_in(run_rev_in),
  .stop_in(stop_in), .analog_terminal_ctrl_en(analog_terminal_ctrl_en), .scurve_en(scurve_en),
  .zero_clamp_en(zero_clamp_en), .zero_clamp_level(zero_clamp_level),
  .speed_window(speed_window), .rotate_threshold(rotate_threshold),
  .speed_ref_out(speed_ref_out), .speed_reached_out(speed_reached_out),
  .rotating_out(rotating_out), .zero_locked_out(zero_locked_out));
